// *** core/fault_response_router.sv ***
`timescale 1ns/100ps
module fault_response_router
	import fault_router_pkg::*;
(
	input  wire logic        core_clk,         // System clock, 10 MHz
	input  wire logic        nrst,             // Async reset, active low
	input  wire logic        even_ecc_single,  // Even bank correctable ECC
	input  wire logic        even_ecc_double,  // Even bank double-bit ECC
	input  wire logic        even_decode,      // Even bank decode mismatch
	input  wire logic        even_addr_par,    // Even bank address parity
	input  wire logic        odd_ecc_single,   // Odd bank correctable ECC
	input  wire logic        odd_ecc_double,   // Odd bank double-bit ECC
	input  wire logic        odd_decode,       // Odd bank decode mismatch
	input  wire logic        odd_addr_par,     // Odd bank address parity
	input  wire logic        flash_corr,       // Flash correctable fault
	input  wire logic        flash_uncorr,     // Flash uncorrectable fault
	input  wire logic        flash_addr_par,   // Flash address parity
	input  wire logic        flash_second_bus, // Flash fault on second bus
	input  wire logic        flash_eeprom,     // Flash fault in EEPROM bank
	input  wire logic        xfer_slave_err,   // Transfer unit ordered slave err
	input  wire logic        xfer_illegal_ok,  // Transfer unit illegal, OK resp
	input  wire logic        xfer_perm,        // Transfer unit permission fault
	input  wire logic        xfer_par,         // Transfer unit memory parity
	input  wire logic        timer_par,        // Timer coprocessor parity
	input  wire logic        serial_par,       // Buffered serial port parity
	input  wire logic        conv_par,         // Buffered converter parity
	input  wire logic        can1_par,         // First CAN parity
	input  wire logic        can2_par,         // Second CAN parity
	input  wire logic        vec_ram_par,      // Vector RAM parity
	input  wire logic        self_test_fail,   // Logic self-test failure
	input  wire logic        fuse_load_fail,   // Fuse autoload failure
	input  wire logic        fuse_stat_any,    // Any fuse error status bit
	input  wire logic        fuse_test_fail,   // Fuse self-test failure
	input  wire logic        watchdog_nmi,     // Watchdog violation, NMI mode
	input  wire logic        supply_bad,       // Supply out of range
	input  wire logic        clock_fail,       // Oscillator fail or PLL slip
	input  wire logic        clk_fail_reset,   // Clock failure reset selected
	input  wire logic [63:0] g1_clear,         // Group 1 flag clear strobes
	input  wire logic [31:0] g2_clear,         // Group 2 flag clear strobes
	input  wire logic [31:0] g3_clear,         // Group 3 flag clear strobes
	input  wire logic [63:0] g1_pin_en,        // Group 1 pin drive enable
	input  wire logic [63:0] g1_irq_en,        // Group 1 interrupt enable
	input  wire logic [63:0] g1_hi_prio,       // Group 1 high priority select
	output logic      [63:0] g1_flags,         // Group 1 flags
	output logic      [31:0] g2_flags,         // Group 2 flags
	output logic      [31:0] g3_flags,         // Group 3 flags
	output logic             cpu_abort,        // CPU access abort pulse
	output logic             irq_low,          // Group 1 low priority irq
	output logic             irq_high,         // Group 1 high priority irq
	output logic             nmi,              // Nonmaskable interrupt
	output logic             xfer_irq,         // Transfer unit irq to vectors
	output logic             fault_pin_n,      // External error pin, low active
	output logic             sys_reset         // System reset request
);

	// ----------------------------------------
	// Synchronisation
	// ----------------------------------------
	logic [SRC_N-1:0] raw_vec;
	logic [SRC_N-1:0] p;

	assign raw_vec = {fuse_test_fail, fuse_stat_any, fuse_load_fail, self_test_fail,
		vec_ram_par, can2_par, can1_par, conv_par, serial_par, timer_par, xfer_par,
		xfer_perm, watchdog_nmi, flash_addr_par, flash_uncorr, flash_corr,
		odd_addr_par, odd_decode, odd_ecc_double, odd_ecc_single,
		even_addr_par, even_decode, even_ecc_single};

	fault_sync #(.W(SRC_N)) u_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.raw_in   (raw_vec),
		.pulse    (p)
	);

	// Even double-bit is kept apart: it also aborts
	logic [3:0] x_p;
	fault_sync #(.W(4)) u_sync_x (
		.core_clk (core_clk),
		.nrst     (nrst),
		.raw_in   ({xfer_illegal_ok, xfer_slave_err, even_ecc_double, clock_fail}),
		.pulse    (x_p)
	);

	logic ev_single, ev_decode, ev_apar, od_single, od_double, od_decode, od_apar;
	logic fl_corr, fl_uncorr, fl_apar, wd_nmi, xf_perm, xf_par, tm_par, sp_par;
	logic cv_par, c1_par, c2_par, vr_par, st_fail, fz_load, fz_stat, fz_test;
	logic ev_double, ck_fail;

	assign {fz_test, fz_stat, fz_load, st_fail, vr_par, c2_par, c1_par, cv_par,
		sp_par, tm_par, xf_par, xf_perm, wd_nmi, fl_apar, fl_uncorr, fl_corr,
		od_apar, od_decode, od_double, od_single, ev_apar, ev_decode, ev_single} = p;
	assign ev_double = x_p[1];
	assign ck_fail   = x_p[0];

	// Bus qualifiers are levels that accompany the fault pulse
	logic sec_bus, eep;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sec_bus <= 1'b0;
			eep     <= 1'b0;
		end else begin
			sec_bus <= flash_second_bus;
			eep     <= flash_eeprom;
		end
	end
	logic sec_d, eep_d;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sec_d <= 1'b0;
			eep_d <= 1'b0;
		end else begin
			sec_d <= sec_bus;
			eep_d <= eep;
		end
	end

	// ----------------------------------------
	// Channel set vectors
	// ----------------------------------------
	logic [63:0] g1_set;
	logic [31:0] g2_set;
	logic [31:0] g3_set;

	always_comb begin
		g1_set = '0;
		g1_set[G1_EVEN_CORR]   = ev_single;
		g1_set[G1_ODD_CORR]    = od_single;
		g1_set[G1_FLASH_CORR]  = fl_corr & ~eep_d;
		g1_set[G1_EEP_CORR]    = fl_corr & eep_d;
		g1_set[G1_EEP_UNCORR]  = fl_uncorr & eep_d;
		g1_set[G1_XFER_PERM]   = xf_perm;
		g1_set[G1_XFER_PAR]    = xf_par;
		g1_set[G1_TIMER_PAR]   = tm_par;
		g1_set[G1_SERIAL_PAR]  = sp_par;
		g1_set[G1_CONV_PAR]    = cv_par;
		g1_set[G1_CAN1_PAR]    = c1_par;
		g1_set[G1_CAN2_PAR]    = c2_par;
		g1_set[G1_VEC_RAM_PAR] = vr_par;
		g1_set[G1_SELF_TEST]   = st_fail;
		g1_set[G1_FUSE_STAT]   = fz_stat;
		g1_set[G1_FUSE_TEST]   = fz_test;
	end

	always_comb begin
		g2_set = '0;
		g2_set[G2_EVEN_DECODE] = ev_decode;
		g2_set[G2_EVEN_APAR]   = ev_apar;
		g2_set[G2_ODD_DECODE]  = od_decode;
		g2_set[G2_ODD_APAR]    = od_apar;
		g2_set[G2_FLASH_APAR]  = fl_apar & ~sec_d;
		g2_set[G2_WATCHDOG]    = wd_nmi;
	end

	// Address parity is its own channel, so uncorrectable excludes it
	logic fl_unc_main;
	assign fl_unc_main = fl_uncorr & ~eep_d & ~fl_apar;

	always_comb begin
		g3_set = '0;
		g3_set[G3_EVEN_UNCORR]  = ev_double;
		g3_set[G3_ODD_UNCORR]   = od_double;
		g3_set[G3_FLASH_UNCORR] = fl_unc_main;
		g3_set[G3_FUSE_LOAD]    = fz_load;
	end

	// ----------------------------------------
	// Sticky flags
	// ----------------------------------------
	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			g1_flags <= G1_RST;
			g2_flags <= G23_RST;
			g3_flags <= G23_RST;
		end else begin
			g1_flags <= (g1_flags & ~g1_clear) | g1_set;
			g2_flags <= (g2_flags & ~g2_clear) | g2_set;
			g3_flags <= (g3_flags & ~g3_clear) | g3_set;
		end
	end

	// ----------------------------------------
	// Responses
	// ----------------------------------------
	logic abort_nxt;
	assign abort_nxt = ev_double | od_double | (fl_unc_main & ~sec_d);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cpu_abort <= 1'b0;
			xfer_irq  <= 1'b0;
		end else begin
			cpu_abort <= abort_nxt;
			xfer_irq  <= x_p[2] | x_p[3];
		end
	end

	// Interrupts are levels that follow the flags one cycle later
	logic [63:0] g1_act;
	assign g1_act = g1_flags & g1_irq_en;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			irq_low  <= 1'b0;
			irq_high <= 1'b0;
			nmi      <= 1'b0;
		end else begin
			irq_low  <= |(g1_act & ~g1_hi_prio);
			irq_high <= |(g1_act & g1_hi_prio);
			nmi      <= |g2_flags;
		end
	end

	// Group 3 never raises an interrupt, only the pin
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			fault_pin_n <= 1'b1;
		end else begin
			fault_pin_n <= ~(|(g1_flags & g1_pin_en) | (|g2_flags) | (|g3_flags));
		end
	end

	// Reset bypasses the flag groups entirely
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sys_reset <= 1'b0;
		end else begin
			sys_reset <= supply_bad | (ck_fail & clk_fail_reset);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_even_corr: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(g1_flags[G1_EVEN_CORR]) |-> !cpu_abort ##1 !cpu_abort)
		else $error("even correctable caused abort");
	a_even_double: assert property (@(posedge core_clk) disable iff (!nrst)
		ev_double |=> cpu_abort && g3_flags[G3_EVEN_UNCORR] ##1 !fault_pin_n)
		else $error("even double fault response missing");
	a_odd_double: assert property (@(posedge core_clk) disable iff (!nrst)
		od_double |=> cpu_abort && g3_flags[G3_ODD_UNCORR])
		else $error("odd double fault response missing");
	a_g2_nmi_pin: assert property (@(posedge core_clk) disable iff (!nrst)
		$rose(|g2_flags) |=> nmi && !fault_pin_n)
		else $error("group 2 flag gave no nmi or pin");
	a_second_noabort: assert property (@(posedge core_clk) disable iff (!nrst)
		fl_unc_main && sec_d && !ev_double && !od_double |=> !cpu_abort)
		else $error("second bus fault aborted");
	a_eep_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		fl_uncorr && eep_d |-> !g3_set[G3_FLASH_UNCORR] ##1 g1_flags[G1_EEP_UNCORR])
		else $error("eeprom fault misrouted");
	a_g3_no_irq: assert property (@(posedge core_clk) disable iff (!nrst)
		g3_flags != 32'h0 && g2_flags == 32'h0 && g1_act == 64'h0 |=> !nmi && !irq_low)
		else $error("group 3 raised interrupt");
	a_clk_reset: assert property (@(posedge core_clk) disable iff (!nrst)
		ck_fail && !clk_fail_reset && !supply_bad |=> !sys_reset)
		else $error("clock reset while not selected");
	a_supply_reset: assert property (@(posedge core_clk) disable iff (!nrst)
		supply_bad |=> sys_reset)
		else $error("supply fault did not reset");
	a_sticky_set: assert property (@(posedge core_clk) disable iff (!nrst)
		g1_set[G1_SELF_TEST] && g1_clear[G1_SELF_TEST] |=> g1_flags[G1_SELF_TEST])
		else $error("set lost to clear");

	// ----------------------------------------
	// Per-source routing checks
	// ----------------------------------------
	a_even_corr_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		ev_single |=> g1_flags[G1_EVEN_CORR])
		else $error("even correctable flag missing");
	a_even_decode: assert property (@(posedge core_clk) disable iff (!nrst)
		ev_decode |=> g2_flags[G2_EVEN_DECODE] ##1 nmi && !fault_pin_n)
		else $error("even decode response missing");
	a_even_apar: assert property (@(posedge core_clk) disable iff (!nrst)
		ev_apar |=> g2_flags[G2_EVEN_APAR])
		else $error("even address parity flag missing");
	a_odd_corr_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		od_single |=> g1_flags[G1_ODD_CORR])
		else $error("odd correctable flag missing");
	a_odd_decode: assert property (@(posedge core_clk) disable iff (!nrst)
		od_decode |=> g2_flags[G2_ODD_DECODE])
		else $error("odd decode flag missing");
	a_odd_apar: assert property (@(posedge core_clk) disable iff (!nrst)
		od_apar |=> g2_flags[G2_ODD_APAR])
		else $error("odd address parity flag missing");
	a_flash_corr: assert property (@(posedge core_clk) disable iff (!nrst)
		fl_corr && !eep_d |=> g1_flags[G1_FLASH_CORR])
		else $error("flash correctable flag missing");
	a_flash_first: assert property (@(posedge core_clk) disable iff (!nrst)
		fl_uncorr && !eep_d && !fl_apar && !sec_d |=> cpu_abort && g3_flags[G3_FLASH_UNCORR])
		else $error("first bus flash fault response missing");
	a_flash_apar: assert property (@(posedge core_clk) disable iff (!nrst)
		fl_apar && !sec_d |=> g2_flags[G2_FLASH_APAR])
		else $error("flash address parity flag missing");
	a_xfer_irq: assert property (@(posedge core_clk) disable iff (!nrst)
		x_p[2] || x_p[3] |=> xfer_irq)
		else $error("transfer unit irq missing");
	a_xfer_perm: assert property (@(posedge core_clk) disable iff (!nrst)
		xf_perm |=> g1_flags[G1_XFER_PERM])
		else $error("transfer permission flag missing");
	a_self_test: assert property (@(posedge core_clk) disable iff (!nrst)
		st_fail |=> g1_flags[G1_SELF_TEST])
		else $error("self-test flag missing");
	a_fuse_load: assert property (@(posedge core_clk) disable iff (!nrst)
		fz_load |=> g3_flags[G3_FUSE_LOAD] ##1 !fault_pin_n)
		else $error("fuse load response missing");
	a_fuse_stat: assert property (@(posedge core_clk) disable iff (!nrst)
		fz_stat |=> g1_flags[G1_FUSE_STAT])
		else $error("fuse status flag missing");
	a_watchdog_nmi: assert property (@(posedge core_clk) disable iff (!nrst)
		wd_nmi |=> g2_flags[G2_WATCHDOG] ##1 nmi && !fault_pin_n)
		else $error("watchdog response missing");
	a_g1_pin_mask: assert property (@(posedge core_clk) disable iff (!nrst)
		(g1_flags & g1_pin_en) == 64'h0 && g2_flags == 32'h0 && g3_flags == 32'h0 |=> fault_pin_n)
		else $error("masked flag drove pin");

	c_even_double: cover property (@(posedge core_clk) disable iff (!nrst) ev_double ##2 !fault_pin_n);
	c_watchdog: cover property (@(posedge core_clk) disable iff (!nrst) wd_nmi ##2 nmi);
	c_sys_reset: cover property (@(posedge core_clk) disable iff (!nrst) $rose(sys_reset));
	c_g1_high: cover property (@(posedge core_clk) disable iff (!nrst) $rose(irq_high));

endmodule

// *** core/fault_router_pkg.sv ***
package fault_router_pkg;

	// ----------------------------------------
	// Group sizes
	// ----------------------------------------
	localparam int G1_CH = 64;
	localparam int G2_CH = 32;
	localparam int G3_CH = 32;

	// ----------------------------------------
	// Channel positions
	// ----------------------------------------
	localparam int G1_FLASH_CORR    = 6;
	localparam int G1_TIMER_PAR     = 7;
	localparam int G1_XFER_PAR      = 8;
	localparam int G1_XFER_PERM     = 9;
	localparam int G1_VEC_RAM_PAR   = 15;
	localparam int G1_SERIAL_PAR    = 17;
	localparam int G1_CONV_PAR      = 19;
	localparam int G1_CAN1_PAR      = 21;
	localparam int G1_CAN2_PAR      = 23;
	localparam int G1_EVEN_CORR     = 26;
	localparam int G1_SELF_TEST     = 27;
	localparam int G1_ODD_CORR      = 28;
	localparam int G1_EEP_CORR      = 35;
	localparam int G1_EEP_UNCORR    = 36;
	localparam int G1_FUSE_STAT     = 40;
	localparam int G1_FUSE_TEST     = 41;
	localparam int G2_FLASH_APAR    = 4;
	localparam int G2_EVEN_DECODE   = 6;
	localparam int G2_ODD_DECODE    = 8;
	localparam int G2_EVEN_APAR     = 10;
	localparam int G2_ODD_APAR      = 12;
	localparam int G2_WATCHDOG      = 24;
	localparam int G3_FUSE_LOAD     = 1;
	localparam int G3_EVEN_UNCORR   = 3;
	localparam int G3_ODD_UNCORR    = 5;
	localparam int G3_FLASH_UNCORR  = 7;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [63:0] G1_RST = 64'h0;
	localparam logic [31:0] G23_RST = 32'h0;

	// Number of fault sources on the raw input vector
	localparam int SRC_N = 23;

endpackage

// *** core/fault_sync.sv ***
`timescale 1ns/100ps
// Two-stage synchroniser plus rising-edge pulse for a vector of fault lines
module fault_sync #(
	parameter int W = 8
) (
	input  wire logic         core_clk, // System clock
	input  wire logic         nrst,     // Async reset, active low
	input  wire logic [W-1:0] raw_in,   // Raw fault levels
	output logic      [W-1:0] pulse     // One-cycle rising-edge pulses
);
	logic [W-1:0] meta_r;
	logic [W-1:0] stable_r;
	logic [W-1:0] prev_r;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			meta_r   <= '0;
			stable_r <= '0;
			prev_r   <= '0;
		end else begin
			meta_r   <= raw_in;
			stable_r <= meta_r;
			prev_r   <= stable_r;
		end
	end

	// Edge taken from the second stage only, never the first
	assign pulse = stable_r & ~prev_r;
endmodule

// *** test/fault_clear_model.sv ***
`timescale 1ns/100ps
module fault_clear_model
	import fault_router_pkg::*;
(
	input  wire logic        core_clk, // System clock
	input  wire logic        nrst,     // Async reset, active low
	input  wire logic        clr_req,  // Handler clear request
	input  wire logic [63:0] g1_flags, // Group 1 flags seen
	input  wire logic [31:0] g2_flags, // Group 2 flags seen
	input  wire logic [31:0] g3_flags, // Group 3 flags seen
	output logic      [63:0] g1_clear, // Group 1 clear strobes
	output logic      [31:0] g2_clear, // Group 2 clear strobes
	output logic      [31:0] g3_clear  // Group 3 clear strobes
);
	// ----------------------------------------
	// Handler write-back
	// ----------------------------------------
	// Clears only flags seen set, so a stray strobe cannot hide a late fault
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			g1_clear <= G1_RST;
			g2_clear <= G23_RST;
			g3_clear <= G23_RST;
		end else begin
			g1_clear <= clr_req ? g1_flags : G1_RST;
			g2_clear <= clr_req ? g2_flags : G23_RST;
			g3_clear <= clr_req ? g3_flags : G23_RST;
		end
	end
endmodule

// *** test/fault_response_router_tb_top.sv ***
`timescale 1ns/100ps
module fault_response_router_tb_top
	import fault_router_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [63:0] N1 = 64'h0;
	localparam logic [31:0] N2 = 32'h0;
	logic        core_clk, nrst, sec, eep, supply_bad, clk_fail_reset, clr_req;
	logic [26:0] flt;
	logic [63:0] g1_pin_en, g1_irq_en, g1_hi_prio, g1_clear, g1_flags;
	logic [31:0] g2_clear, g3_clear, g2_flags, g3_flags;
	logic        cpu_abort, irq_low, irq_high, nmi, xfer_irq, fault_pin_n, sys_reset;
	int          errors, tests_run;

	always #50 core_clk = ~core_clk;

	fault_response_router dut (.core_clk(core_clk), .nrst(nrst),
		.even_ecc_single(flt[0]), .even_ecc_double(flt[1]), .even_decode(flt[2]),
		.even_addr_par(flt[3]), .odd_ecc_single(flt[4]), .odd_ecc_double(flt[5]),
		.odd_decode(flt[6]), .odd_addr_par(flt[7]), .flash_corr(flt[8]),
		.flash_uncorr(flt[9]), .flash_addr_par(flt[10]), .flash_second_bus(sec),
		.flash_eeprom(eep), .xfer_slave_err(flt[11]), .xfer_illegal_ok(flt[12]),
		.xfer_perm(flt[13]), .xfer_par(flt[14]), .timer_par(flt[15]),
		.serial_par(flt[16]), .conv_par(flt[17]), .can1_par(flt[18]),
		.can2_par(flt[19]), .vec_ram_par(flt[20]), .self_test_fail(flt[21]),
		.fuse_load_fail(flt[22]), .fuse_stat_any(flt[23]), .fuse_test_fail(flt[24]),
		.watchdog_nmi(flt[25]), .supply_bad(supply_bad), .clock_fail(flt[26]),
		.clk_fail_reset(clk_fail_reset), .g1_clear(g1_clear), .g2_clear(g2_clear),
		.g3_clear(g3_clear), .g1_pin_en(g1_pin_en), .g1_irq_en(g1_irq_en),
		.g1_hi_prio(g1_hi_prio), .g1_flags(g1_flags), .g2_flags(g2_flags),
		.g3_flags(g3_flags), .cpu_abort(cpu_abort), .irq_low(irq_low),
		.irq_high(irq_high), .nmi(nmi), .xfer_irq(xfer_irq),
		.fault_pin_n(fault_pin_n), .sys_reset(sys_reset));

	fault_clear_model far (.core_clk(core_clk), .nrst(nrst), .clr_req(clr_req),
		.g1_flags(g1_flags), .g2_flags(g2_flags), .g3_flags(g3_flags),
		.g1_clear(g1_clear), .g2_clear(g2_clear), .g3_clear(g3_clear));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [26:0] b(input int k);
		return 27'h1 << k;
	endfunction
	function automatic logic [63:0] f1(input int k);
		return 64'h1 << k;
	endfunction
	function automatic logic [31:0] f2(input int k);
		return 32'h1 << k;
	endfunction

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic test_done;
		$display("checks run %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One-cycle fault pulse, expected flags, then handler clear.
	// fl = {second bus, eeprom, abort expected, transfer irq expected}
	task automatic route(input logic [26:0] m, input logic [3:0] fl,
		input logic [63:0] e1, input logic [31:0] e2, input logic [31:0] e3);
		logic ab, xi, rs;
		logic [63:0] en;
		ab = 1'h0;
		xi = 1'h0;
		rs = 1'h0;
		@(posedge core_clk);
		flt <= m;
		sec <= fl[3];
		eep <= fl[2];
		@(posedge core_clk);
		flt <= 27'h0;
		for (int i = 0; i < 10; i++) begin
			@(posedge core_clk);
			#1 ab |= cpu_abort;
			xi |= xfer_irq;
			rs |= sys_reset;
		end
		en = e1 & g1_irq_en;
		chk("g1_flags", e1, g1_flags);
		chk("g2_flags", {N2, e2}, {N2, g2_flags});
		chk("g3_flags", {N2, e3}, {N2, g3_flags});
		chk("irq_low", |(en & ~g1_hi_prio), irq_low);
		chk("irq_high", |(en & g1_hi_prio), irq_high);
		chk("nmi", |e2, nmi);
		chk("fault_pin_n", !((|(e1 & g1_pin_en)) || (|e2) || (|e3)), fault_pin_n);
		chk("cpu_abort", fl[1], ab);
		chk("xfer_irq", fl[0], xi);
		chk("sys_reset", 64'h0, rs);
		@(posedge core_clk);
		clr_req <= 1'h1;
		@(posedge core_clk);
		clr_req <= 1'h0;
		sec <= 1'h0;
		eep <= 1'h0;
		repeat (4) @(posedge core_clk);
		#1 chk("flags cleared", N1, g1_flags | {g2_flags, g3_flags});
		chk("outputs released", 64'h1, {irq_low, irq_high, nmi, fault_pin_n});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_ram;
		route(b(0), 4'h0, f1(26), N2, N2);
		route(b(1), 4'h2, N1, N2, f2(3));
		route(b(2), 4'h0, N1, f2(6), N2);
		route(b(3), 4'h0, N1, f2(10), N2);
		route(b(4), 4'h0, f1(28), N2, N2);
		route(b(5), 4'h2, N1, N2, f2(5));
		route(b(6), 4'h0, N1, f2(8), N2);
		route(b(7), 4'h0, N1, f2(12), N2);
	endtask

	task automatic t_flash;
		route(b(8), 4'h0, f1(6), N2, N2);
		route(b(8), 4'h8, f1(6), N2, N2);
		route(b(9), 4'h2, N1, N2, f2(7));
		route(b(9), 4'h8, N1, N2, f2(7));
		route(b(10), 4'h0, N1, f2(4), N2);
		route(b(10), 4'h8, N1, N2, N2);
		route(b(9) | b(10), 4'h0, N1, f2(4), N2);
		route(b(8), 4'h4, f1(35), N2, N2);
		route(b(9), 4'h4, f1(36), N2, N2);
	endtask

	task automatic t_periph;
		route(b(11), 4'h1, N1, N2, N2);
		route(b(12), 4'h1, N1, N2, N2);
		route(b(13), 4'h0, f1(9), N2, N2);
		route(b(14), 4'h0, f1(8), N2, N2);
		route(b(15), 4'h0, f1(7), N2, N2);
		route(b(16), 4'h0, f1(17), N2, N2);
		route(b(17), 4'h0, f1(19), N2, N2);
		route(b(18), 4'h0, f1(21), N2, N2);
		route(b(19), 4'h0, f1(23), N2, N2);
		route(b(20), 4'h0, f1(15), N2, N2);
		route(b(21), 4'h0, f1(27), N2, N2);
		route(b(22), 4'h0, N1, N2, f2(1));
		route(b(23), 4'h0, f1(40), N2, N2);
		route(b(24), 4'h0, f1(41), N2, N2);
		route(b(25), 4'h0, N1, f2(24), N2);
	endtask

	task automatic t_group1_cfg;
		@(posedge core_clk);
		g1_pin_en <= f1(26);
		g1_hi_prio <= f1(26);
		route(b(0), 4'h0, f1(26), N2, N2);
		@(posedge core_clk);
		g1_irq_en <= ~f1(28);
		route(b(4) | b(5), 4'h2, f1(28), N2, f2(5));
		@(posedge core_clk);
		g1_pin_en <= N1;
		g1_hi_prio <= N1;
		g1_irq_en <= ~N1;
	endtask

	// Second event lands in the same cycle as the handler clear
	task automatic t_set_wins;
		@(posedge core_clk);
		flt <= b(21);
		@(posedge core_clk);
		flt <= 27'h0;
		repeat (4) @(posedge core_clk);
		flt <= b(21);
		@(posedge core_clk);
		flt <= 27'h0;
		clr_req <= 1'h1;
		@(posedge core_clk);
		clr_req <= 1'h0;
		repeat (2) @(posedge core_clk);
		#1 chk("set beats clear", 64'h1, g1_flags[27]);
		@(posedge core_clk);
		clr_req <= 1'h1;
		@(posedge core_clk);
		clr_req <= 1'h0;
		repeat (3) @(posedge core_clk);
		#1 chk("flag cleared after set", N1, g1_flags);
		chk("outputs after set", 64'h1, {irq_low, irq_high, nmi, fault_pin_n});
	endtask

	task automatic t_resets;
		logic seen;
		seen = 1'h0;
		@(posedge core_clk);
		supply_bad <= 1'h1;
		repeat (2) @(posedge core_clk);
		#1 chk("sys_reset on supply", 64'h1, sys_reset);
		chk("flags on supply", N1, g1_flags | {g2_flags, g3_flags});
		@(posedge core_clk);
		supply_bad <= 1'h0;
		repeat (3) @(posedge core_clk);
		#1 chk("sys_reset after supply", 64'h0, sys_reset);
		route(b(26), 4'h0, N1, N2, N2);
		@(posedge core_clk);
		clk_fail_reset <= 1'h1;
		flt <= b(26);
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			#1 seen |= sys_reset;
		end
		chk("sys_reset on clock fail", 64'h1, seen);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'h0;
		nrst = 1'h0;
		flt = 27'h0;
		{sec, eep, supply_bad, clk_fail_reset, clr_req} = 5'h0;
		g1_pin_en = N1;
		g1_irq_en = ~N1;
		g1_hi_prio = N1;
		errors = 0;
		tests_run = 0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'h1;
		@(posedge core_clk);
		#1 chk("pin idle", 64'h1, fault_pin_n);
		t_ram;
		t_flash;
		t_periph;
		t_group1_cfg;
		t_set_wins;
		t_resets;
		test_done;
	end
endmodule
